// ### stepper_drive_config_regs.sv
/*
 * Configuration register bank of the stepper drive: serial frame receiver on
 * the host's clock, six 12-bit settings registers on the core clock, and the
 * logic that turns those settings into drive timing and stall/overcurrent flags.
 * Assumes the host raises scs at least three mclk periods before its first sclk
 * edge, and leaves it high for at least one mclk period after the 16th edge.
 */
`timescale 1ns/1ps

module stepper_drive_config_regs
    import stepper_cfg_pkg::*;
#(
    parameter int DEG_CNT_W = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scs,
    input wire logic sclk,
    input wire logic sdati,
    output logic sdato,
    input wire logic [3:0] indexer_drive,
    input wire logic [3:0] bridge_direct_inputs,
    output logic [3:0] bridge_drive,
    input wire logic current_rising,
    input wire logic bemf_valid,
    input wire logic [DATA_W-1:0] bemf_level,
    output logic stall_out_n,
    input wire logic overcurrent_raw,
    output logic overcurrent_trip,
    output decay_e decay_now,
    output out_s drive_settings,
    output logic [7:0] min_on_cycles
);

    function automatic word_t wr_mask(input addr_t a);
        if (a == REG_CURRENT) begin
            return CURRENT_WMASK;
        end else if (a == REG_OFF) begin
            return OFF_WMASK;
        end else if (a == REG_BLANK) begin
            return BLANK_WMASK;
        end else if (a == REG_DECAY) begin
            return DECAY_WMASK;
        end else if (a == REG_STALL) begin
            return STALL_WMASK;
        end else if (a == REG_DRIVE) begin
            return DRIVE_WMASK;
        end else begin
            return '0;
        end
    endfunction

    function automatic cfg_s wr_apply(input cfg_s c, input addr_t a, input word_t d);
        cfg_s r;
        word_t m;
        r = c;
        m = wr_mask(a);
        if (a == REG_CURRENT) begin
            r.current = d & m;
        end else if (a == REG_OFF) begin
            r.off = d & m;
        end else if (a == REG_BLANK) begin
            r.blank = d & m;
        end else if (a == REG_DECAY) begin
            r.decay = d & m;
        end else if (a == REG_STALL) begin
            r.stall = d & m;
        end else if (a == REG_DRIVE) begin
            r.drive = d & m;
        end
        return r;
    endfunction

    function automatic word_t rd_value(input cfg_s c, input addr_t a);
        if (a == REG_CURRENT) begin
            return c.current & CURRENT_RMASK;
        end else if (a == REG_OFF) begin
            return c.off;
        end else if (a == REG_BLANK) begin
            return c.blank;
        end else if (a == REG_DECAY) begin
            return c.decay;
        end else if (a == REG_STALL) begin
            return c.stall;
        end else if (a == REG_DRIVE) begin
            return c.drive;
        end else begin
            return '0;
        end
    endfunction

    function automatic logic [7:0] blank_cycles(input logic [7:0] code);
        int ns;
        if (code <= BLANK_FLOOR_CODE) begin
            ns = BLANK_MIN_NS;
        end else begin
            ns = (int'(code) + 1) * BLANK_STEP_NS;
        end
        // Least time: round up to whole cycles
        return 8'((ns + MCLK_NS - 1) / MCLK_NS);
    endfunction

    function automatic out_s decode_cfg(input cfg_s c);
        out_s o;
        o.full_scale = c.current[7:0];
        o.sample_us = SAMPLE_US_TABLE[c.current[SAMPLE_TH_MSB:SAMPLE_TH_LSB]];
        o.off_cyc = 12'((int'(c.off[7:0]) + 1) * (OFF_STEP_NS / MCLK_NS));
        o.blank_cyc = blank_cycles(c.blank[7:0]);
        o.adaptive_blank = c.blank[ADAPT_BIT];
        o.decay_cyc = 12'(int'(c.decay[7:0]) * (DECAY_STEP_NS / MCLK_NS));
        o.ocp_mv = 10'((int'(c.drive[OC_TH_LSB+:2]) + 1) * OCP_STEP_MV);
        o.lo_drv_cyc = 8'((DRIVE_BASE_NS / MCLK_NS) << c.drive[TDRN_LSB+:2]);
        o.hi_drv_cyc = 8'((DRIVE_BASE_NS / MCLK_NS) << c.drive[TDRP_LSB+:2]);
        o.sink_ma = 9'((int'(c.drive[IDRN_LSB+:2]) + 1) * SINK_STEP_MA);
        o.source_ma = 8'((int'(c.drive[IDRP_LSB+:2]) + 1) * SOURCE_STEP_MA);
        return o;
    endfunction

    function automatic decay_e resolve_decay(input logic [2:0] code, input logic bypass,
                                             input logic rising);
        case (code)
            DM_SLOW: return DECAY_SLOW;
            DM_FAST: return DECAY_FAST;
            DM_MIXED: return DECAY_MIXED;
            DM_AUTO: return DECAY_AUTO;
            // Direction only known from the indexer; bypass falls back
            DM_SLOW_MIXED: return (!bypass && rising) ? DECAY_SLOW : DECAY_MIXED;
            DM_SLOW_AUTO: return (!bypass && rising) ? DECAY_SLOW : DECAY_AUTO;
            default: return DECAY_SLOW;
        endcase
    endfunction

    localparam out_s OUT_RST = decode_cfg(CFG_RST);
    localparam logic [DEG_CNT_W-1:0] DEG_BASE_CYC = DEG_CNT_W'(DEGLITCH_BASE_NS / MCLK_NS);

    typedef struct packed {
        link_phase_e phase;
        logic [4:0] cnt;
        logic [HDR_BITS-1:0] hdr;
        logic [FRAME_BITS-1:0] shift;
    } link_s;

    typedef struct packed {
        logic [FRAME_BITS-1:0] word;
        logic tog;
    } done_s;

    typedef struct packed {
        cfg_s cfg;
        logic [NUM_ADDR-1:0][DATA_W-1:0] shadow;
        logic scs_s1;
        logic scs_s2;
        logic tog_s1;
        logic tog_s2;
        logic tog_seen;
        logic [3:0] dir_s1;
        logic [3:0] dir_s2;
        logic oc_s1;
        logic oc_s2;
        logic [3:0] bridge;
        decay_e decay;
        logic [3:0] stall_cnt;
        logic stall_n;
        logic [DEG_CNT_W-1:0] deg_cnt;
        logic oc_trip;
        out_s out;
    } core_s;

    localparam link_s LINK_RST = '{phase: LK_HEADER, cnt: '0, hdr: '0, shift: '0};
    localparam core_s CORE_RST = '{cfg: CFG_RST, shadow: '0, scs_s1: 1'b0, scs_s2: 1'b0,
        tog_s1: 1'b0, tog_s2: 1'b0, tog_seen: 1'b0, dir_s1: '0, dir_s2: '0, oc_s1: 1'b0,
        oc_s2: 1'b0, bridge: '0, decay: DECAY_SLOW, stall_cnt: '0, stall_n: 1'b1,
        deg_cnt: '0, oc_trip: 1'b0, out: OUT_RST};

    link_s lk;
    link_s next_lk;
    done_s done;
    done_s next_done;
    core_s st;
    core_s next_st;
    logic sdato_q;
    logic frame_rst;
    logic [3:0] out_idx;

    // Link side: the host clock stops between frames, so scs ends each frame
    assign frame_rst = sys_rst | ~scs;

    always_comb begin
        next_lk = lk;
        next_done = done;
        if (lk.cnt < 5'(FRAME_BITS)) begin
            next_lk.shift = {lk.shift[FRAME_BITS-2:0], sdati};
            next_lk.cnt = lk.cnt + 5'h1;
        end
        case (lk.phase)
            LK_HEADER: begin
                if (lk.cnt == 5'(HDR_BITS - 1)) begin
                    next_lk.hdr = {lk.shift[HDR_BITS-2:0], sdati};
                    next_lk.phase = LK_DATA;
                end
            end
            LK_DATA: begin
                if (lk.cnt == 5'(FRAME_BITS - 1)) begin
                    next_done.word = {lk.shift[FRAME_BITS-2:0], sdati};
                    next_done.tog = ~done.tog;
                end
            end
            default: next_lk.phase = LK_HEADER;
        endcase
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            lk <= LINK_RST;
        end else begin
            lk <= next_lk;
        end
    end

    // Completed word must outlive the frame, so only the system reset clears it
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            done <= '0;
        end else begin
            done <= next_done;
        end
    end

    assign out_idx = 4'(5'(FRAME_BITS - 1) - lk.cnt);

    // Shadow is frozen while scs is high, so it is stable for the whole frame
    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            sdato_q <= 1'b0;
        end else if (lk.phase == LK_DATA && lk.hdr[HDR_BITS-1] && lk.cnt < 5'(FRAME_BITS)) begin
            sdato_q <= st.shadow[lk.hdr[ADDR_W-1:0]][out_idx];
        end else begin
            sdato_q <= 1'b0;
        end
    end

    assign sdato = sdato_q;

    // Core side
    always_comb begin
        logic [DATA_W-1:0] scaled;
        logic [3:0] need;
        logic [DEG_CNT_W-1:0] deg_need;
        logic below;
        scaled = '0;
        need = '0;
        deg_need = '0;
        below = 1'b0;
        next_st = st;
        next_st.scs_s1 = scs;
        next_st.scs_s2 = st.scs_s1;
        next_st.tog_s1 = done.tog;
        next_st.tog_s2 = st.tog_s1;
        next_st.dir_s1 = bridge_direct_inputs;
        next_st.dir_s2 = st.dir_s1;
        next_st.oc_s1 = overcurrent_raw;
        next_st.oc_s2 = st.oc_s1;

        // Word stays put until the next frame's 16th edge, far later
        if (st.tog_s2 != st.tog_seen) begin
            next_st.tog_seen = st.tog_s2;
            if (!done.word[RW_BIT]) begin
                next_st.cfg = wr_apply(st.cfg, done.word[ADDR_LSB+:ADDR_W],
                                       done.word[DATA_W-1:0]);
            end
        end
        if (!st.scs_s2) begin
            for (int i = 0; i < NUM_ADDR; i++) begin
                next_st.shadow[i] = rd_value(st.cfg, addr_t'(i));
            end
        end

        next_st.out = decode_cfg(st.cfg);
        next_st.bridge = st.cfg.off[BYPASS_BIT] ? st.dir_s2 : indexer_drive;
        next_st.decay = resolve_decay(st.cfg.decay[MODE_MSB:MODE_LSB],
                                      st.cfg.off[BYPASS_BIT], current_rising);

        scaled = bemf_level >> (3'(DIV_SHIFT_MAX) - {1'b0, st.cfg.stall[DIV_LSB+:2]});
        below = scaled < {4'h0, st.cfg.stall[7:0]};
        need = 4'h1 << st.cfg.stall[STALL_CNT_LSB+:2];
        if (bemf_valid) begin
            if (below) begin
                if (st.stall_cnt < need) begin
                    next_st.stall_cnt = st.stall_cnt + 4'h1;
                end
                if (st.stall_cnt + 4'h1 >= need) begin
                    next_st.stall_n = 1'b0;
                end
            end else begin
                next_st.stall_cnt = '0;
                next_st.stall_n = 1'b1;
            end
        end

        deg_need = DEG_BASE_CYC << st.cfg.drive[OC_DEG_LSB+:2];
        if (!st.oc_s2) begin
            next_st.deg_cnt = '0;
            next_st.oc_trip = 1'b0;
        end else if (st.deg_cnt == deg_need) begin
            next_st.oc_trip = 1'b1;
        end else begin
            next_st.deg_cnt = st.deg_cnt + DEG_CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= CORE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign bridge_drive = st.bridge;
    assign decay_now = st.decay;
    assign stall_out_n = st.stall_n;
    assign overcurrent_trip = st.oc_trip;
    assign drive_settings = st.out;
    assign min_on_cycles = st.out.blank_cyc;

    a_reset_defaults: assert property (@(posedge mclk)
        sys_rst |-> st.cfg == CFG_RST && stall_out_n)
        else $error("registers not at defaults during reset");

    a_write_lands: assert property (@(posedge mclk) disable iff (sys_rst)
        (st.tog_s2 != st.tog_seen && !done.word[RW_BIT]
         && done.word[ADDR_LSB+:ADDR_W] == REG_OFF)
        |=> st.cfg.off == ($past(done.word[DATA_W-1:0]) & OFF_WMASK))
        else $error("write to off time register did not land");

    a_write_only_bit: assert property (@(posedge mclk) disable iff (sys_rst)
        !st.shadow[REG_CURRENT][SAMPLE_TH_MSB])
        else $error("write-only bit visible on read");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        st.cfg.off[DATA_W-1:BYPASS_BIT+1] == '0 && st.cfg.blank[DATA_W-1:ADAPT_BIT+1] == '0
        && st.cfg.decay[DATA_W-1] == 1'b0)
        else $error("reserved bit stored");

    a_bypass_mux: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst |=> bridge_drive == ($past(st.cfg.off[BYPASS_BIT]) ? $past(st.dir_s2)
                                                           : $past(indexer_drive)))
        else $error("bridge drive source wrong");

    a_blank_floor: assert property (@(posedge mclk) disable iff (sys_rst)
        st.cfg.blank[7:0] <= BLANK_FLOOR_CODE ##2 st.cfg.blank[7:0] <= BLANK_FLOOR_CODE
        |-> min_on_cycles == 8'(BLANK_MIN_NS / MCLK_NS))
        else $error("blanking floor not applied");

    a_stall_first: assert property (@(posedge mclk) disable iff (sys_rst)
        bemf_valid && st.cfg.stall[STALL_CNT_LSB+:2] == 2'h0
        && (bemf_level >> DIV_SHIFT_MAX) < {4'h0, st.cfg.stall[7:0]}
        && st.cfg.stall[DIV_LSB+:2] == 2'h0 |=> !stall_out_n)
        else $error("stall not flagged on first low step");

    a_stall_release: assert property (@(posedge mclk) disable iff (sys_rst)
        bemf_valid && (bemf_level >> (3'(DIV_SHIFT_MAX) - {1'b0, st.cfg.stall[DIV_LSB+:2]}))
        >= {4'h0, st.cfg.stall[7:0]} |=> stall_out_n && st.stall_cnt == '0)
        else $error("stall not released on good step");

    a_deglitch_gap: assert property (@(posedge mclk) disable iff (sys_rst)
        !st.oc_s2 |=> !overcurrent_trip ##1 !overcurrent_trip)
        else $error("overcurrent trip without a held input");

    a_decay_fast: assert property (@(posedge mclk) disable iff (sys_rst)
        st.cfg.decay[MODE_MSB:MODE_LSB] == DM_FAST |=> decay_now == DECAY_FAST)
        else $error("forced fast decay not applied");

endmodule

// ### stepper_cfg_pkg.sv
/*
 * Constants, field layout, reset values, the sample-time table and carrier types for the
 * stepper drive configuration register bank.
 * Assumes a 20 MHz core clock and a 16-bit serial frame from the host.
 */
package stepper_cfg_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 12;
    localparam int FRAME_BITS = 16;
    localparam int HDR_BITS = 4;
    localparam int RW_BIT = 15;
    localparam int ADDR_LSB = 12;
    localparam int NUM_ADDR = 8;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] word_t;

    localparam addr_t REG_CURRENT = 3'h1;
    localparam addr_t REG_OFF = 3'h2;
    localparam addr_t REG_BLANK = 3'h3;
    localparam addr_t REG_DECAY = 3'h4;
    localparam addr_t REG_STALL = 3'h5;
    localparam addr_t REG_DRIVE = 3'h6;

    localparam word_t CURRENT_RST = 12'h1ff;
    localparam word_t OFF_RST = 12'h030;
    localparam word_t BLANK_RST = 12'h080;
    localparam word_t DECAY_RST = 12'h110;
    localparam word_t STALL_RST = 12'h040;
    localparam word_t DRIVE_RST = 12'ha59;

    // Bits that a write may change; the rest are reserved
    localparam word_t CURRENT_WMASK = 12'h7ff;
    localparam word_t OFF_WMASK = 12'h1ff;
    localparam word_t BLANK_WMASK = 12'h1ff;
    localparam word_t DECAY_WMASK = 12'h7ff;
    localparam word_t STALL_WMASK = 12'hfff;
    localparam word_t DRIVE_WMASK = 12'hfff;
    // Write-only top bit of the sample threshold hidden on read
    localparam word_t CURRENT_RMASK = 12'h3ff;

    localparam int SAMPLE_TH_LSB = 8;
    localparam int SAMPLE_TH_MSB = 10;
    localparam int BYPASS_BIT = 8;
    localparam int ADAPT_BIT = 8;
    localparam int MODE_LSB = 8;
    localparam int MODE_MSB = 10;
    localparam int STALL_CNT_LSB = 8;
    localparam int DIV_LSB = 10;
    localparam int OC_TH_LSB = 0;
    localparam int OC_DEG_LSB = 2;
    localparam int TDRN_LSB = 4;
    localparam int TDRP_LSB = 6;
    localparam int IDRN_LSB = 8;
    localparam int IDRP_LSB = 10;

    localparam int MCLK_NS = 50;
    localparam int OFF_STEP_NS = 500;
    localparam int BLANK_STEP_NS = 20;
    localparam int BLANK_MIN_NS = 1000;
    localparam logic [7:0] BLANK_FLOOR_CODE = 8'h32;
    localparam int DECAY_STEP_NS = 500;
    localparam int DEGLITCH_BASE_NS = 1000;
    localparam int DRIVE_BASE_NS = 250;
    localparam int OCP_STEP_MV = 250;
    localparam int SINK_STEP_MA = 100;
    localparam int SOURCE_STEP_MA = 50;
    localparam int DIV_SHIFT_MAX = 5;
    localparam int SAMPLE_US_W = 10;
    localparam logic [SAMPLE_US_W-1:0] SAMPLE_US_TABLE [NUM_ADDR] = '{
        10'd50, 10'd100, 10'd200, 10'd300, 10'd400, 10'd600, 10'd800, 10'd1000};

    localparam logic [2:0] DM_SLOW = 3'h0;
    localparam logic [2:0] DM_SLOW_MIXED = 3'h1;
    localparam logic [2:0] DM_FAST = 3'h2;
    localparam logic [2:0] DM_MIXED = 3'h3;
    localparam logic [2:0] DM_SLOW_AUTO = 3'h4;
    localparam logic [2:0] DM_AUTO = 3'h5;

    typedef enum logic [3:0] {
        DECAY_SLOW = 4'h1,
        DECAY_FAST = 4'h2,
        DECAY_MIXED = 4'h4,
        DECAY_AUTO = 4'h8
    } decay_e;

    typedef enum logic [1:0] {
        LK_HEADER = 2'h1,
        LK_DATA = 2'h2
    } link_phase_e;

    typedef struct packed {
        word_t current;
        word_t off;
        word_t blank;
        word_t decay;
        word_t stall;
        word_t drive;
    } cfg_s;

    // Settings decoded for the power stage, in core clock cycles where timed, except sample_us in microseconds
    typedef struct packed {
        logic [7:0] full_scale;
        logic [SAMPLE_US_W-1:0] sample_us;
        logic [11:0] off_cyc;
        logic [7:0] blank_cyc;
        logic adaptive_blank;
        logic [11:0] decay_cyc;
        logic [9:0] ocp_mv;
        logic [7:0] lo_drv_cyc;
        logic [7:0] hi_drv_cyc;
        logic [8:0] sink_ma;
        logic [7:0] source_ma;
    } out_s;

    localparam cfg_s CFG_RST = '{current: CURRENT_RST, off: OFF_RST, blank: BLANK_RST,
        decay: DECAY_RST, stall: STALL_RST, drive: DRIVE_RST};

endpackage

// ### host_link_model.sv
/*
 * Behavioural host on the serial link: sends whole 16-bit frames, samples
 * read data on rising sclk edges.
 * Assumes mclk is the core clock, used only to space frames.
 */
`timescale 1ns/1ps
module host_link_model (
    input wire logic mclk,
    output logic scs,
    output logic sclk,
    output logic sdati,
    input wire logic sdato
);
    initial begin
        scs = 1'b0;
        sclk = 1'b0;
        sdati = 1'b0;
    end
    // Link clock runs only inside a frame, 6 ns period
    task automatic frame(input logic [15:0] w, output logic [11:0] r);
        @(posedge mclk);
        scs <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 15; i >= 0; i--) begin
            sdati = w[i];
            #3 sclk = 1'b1;
            if (i < 12) begin
                r[i] = sdato;
            end
            #3 sclk = 1'b0;
        end
        repeat (2) @(posedge mclk);
        scs <= 1'b0;
        // Released line shows no stale value
        sdati = ~sdati;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// ### tb_top.sv
/*
 * Self-checking bench for the stepper configuration register bank.
 * Assumes host_link_model drives the serial link.
 */
`timescale 1ns/1ps
module tb_top;
    import stepper_cfg_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b0;
    wire logic scs, sclk, sdati;
    logic sdato, stall_out_n, trip;
    logic [3:0] ind = 4'h5;
    logic [3:0] dir = 4'ha;
    logic [3:0] bd;
    logic rising = 1'b0;
    logic bv = 1'b0;
    logic [11:0] bl = 12'h000;
    logic ocr = 1'b0;
    decay_e dn;
    out_s ds;
    logic [7:0] mon;
    int n_errors = 0;
    int num_checks = 0;
    logic [11:0] rst_v [8] = '{12'h000, 12'h1ff, 12'h030, 12'h080, 12'h110, 12'h040,
        12'ha59, 12'h000};
    logic [11:0] one_v [8] = '{12'h000, 12'h3ff, 12'h1ff, 12'h1ff, 12'h7ff, 12'hfff,
        12'hfff, 12'h000};
    logic [7:0] bl_c [4] = '{8'h00, 8'h32, 8'h33, 8'hff};
    logic [7:0] bl_y [4] = '{8'h14, 8'h14, 8'h15, 8'h67};
    logic [3:0] dm [16] = '{4'h1, 4'h1, 4'h4, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4,
        4'h8, 4'h1, 4'h8, 4'h8, 4'h1, 4'h1, 4'h1, 4'h1};

    always #25 mclk = ~mclk;

    stepper_drive_config_regs #(.DEG_CNT_W(8)) stepper_drive_config_regs_i (
        .mclk(mclk), .sys_rst(sys_rst), .scs(scs), .sclk(sclk), .sdati(sdati),
        .sdato(sdato), .indexer_drive(ind), .bridge_direct_inputs(dir),
        .bridge_drive(bd), .current_rising(rising), .bemf_valid(bv),
        .bemf_level(bl), .stall_out_n(stall_out_n), .overcurrent_raw(ocr),
        .overcurrent_trip(trip), .decay_now(dn), .drive_settings(ds),
        .min_on_cycles(mon));
    host_link_model host_link_model_i (.mclk(mclk), .scs(scs), .sclk(sclk),
        .sdati(sdati), .sdato(sdato));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        logic [11:0] r;
        host_link_model_i.frame({1'b0, a, d}, r);
    endtask
    task automatic rd(input logic [2:0] a, input logic [11:0] e);
        logic [11:0] r;
        host_link_model_i.frame({1'b1, a, 12'h000}, r);
        chk(16'(r), 16'(e));
    endtask
    task automatic step(input logic [11:0] lv);
        bl <= lv;
        bv <= 1'b1;
        @(posedge mclk);
        bv <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Runs near 1500 mclk cycles; ten times that is a hang
    initial begin
        #800000;
        n_errors++;
        end_of_test();
    end

    initial begin
        // Rising edge at time zero so the asynchronous reset really fires
        sys_rst <= 1'b1;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), rst_v[a]);
        end
        for (int a = 0; a < 8; a++) begin
            wr(3'(a), 12'hfff);
            rd(3'(a), one_v[a]);
        end
        wr(3'h1, 12'h4a5);
        rd(3'h1, 12'h0a5);
        chk(16'(ds.full_scale), 16'h00a5);
        chk(16'(ds.sample_us), 16'h0190);
        wr(3'h1, 12'h700);
        chk(16'(ds.sample_us), 16'h03e8);
        wr(3'h2, 12'h0ff);
        chk(16'(ds.off_cyc), 16'h0a00);
        wr(3'h2, 12'h000);
        chk(16'(ds.off_cyc), 16'h000a);
        for (int i = 0; i < 4; i++) begin
            wr(3'h3, {4'h1, bl_c[i]});
            chk(16'(ds.blank_cyc), 16'(bl_y[i]));
            chk(16'(mon), 16'(bl_y[i]));
            chk(16'(ds.adaptive_blank), 16'h0001);
        end
        wr(3'h3, 12'h080);
        chk(16'(ds.adaptive_blank), 16'h0000);
        wr(3'h4, 12'h1ff);
        chk(16'(ds.decay_cyc), 16'h09f6);
        for (int c = 0; c < 8; c++) begin
            wr(3'h4, {1'b0, 3'(c), 8'h10});
            for (int r = 0; r < 2; r++) begin
                rising <= 1'(r);
                repeat (3) @(posedge mclk);
                chk(16'(dn), 16'(dm[c * 2 + r]));
            end
        end
        wr(3'h2, 12'h130);
        chk(16'(bd), 16'h000a);
        wr(3'h2, 12'h030);
        chk(16'(bd), 16'h0005);
        for (int c = 0; c < 4; c++) begin
            wr(3'h5, {2'b00, 2'(c), 8'h40});
            repeat ((1 << c) - 1) step(12'h7ff);
            chk(16'(stall_out_n), 16'h0001);
            step(12'h7ff);
            chk(16'(stall_out_n), 16'h0000);
            step(12'h800);
            chk(16'(stall_out_n), 16'h0001);
        end
        wr(3'h5, 12'hc40);
        step(12'h0fc);
        chk(16'(stall_out_n), 16'h0000);
        step(12'h100);
        chk(16'(stall_out_n), 16'h0001);
        for (int k = 0; k < 2; k++) begin
            wr(3'h6, k ? 12'hfff : 12'h000);
            chk(16'(ds.ocp_mv), 16'(250 * (3 * k + 1)));
            chk(16'(ds.lo_drv_cyc), 16'(5 << (3 * k)));
            chk(16'(ds.hi_drv_cyc), 16'(5 << (3 * k)));
            chk(16'(ds.sink_ma), 16'(100 * (3 * k + 1)));
            chk(16'(ds.source_ma), 16'(50 * (3 * k + 1)));
        end
        for (int c = 0; c < 4; c++) begin
            wr(3'h6, {8'ha5, 2'(c), 2'b01});
            ocr <= 1'b1;
            repeat ((20 << c) - 2) @(posedge mclk);
            chk(16'(trip), 16'h0000);
            repeat (8) @(posedge mclk);
            chk(16'(trip), 16'h0001);
            ocr <= 1'b0;
            repeat (4) @(posedge mclk);
            chk(16'(trip), 16'h0000);
        end
        wr(3'h2, 12'h055);
        sys_rst <= 1'b1;
        // Frame sent while reset holds must be dropped
        wr(3'h2, 12'h0aa);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(3'h2, 12'h030);
        rd(3'h6, 12'ha59);
        end_of_test();
    end
endmodule
